/* File: hw/tcc_defs.vh */
// Constants for the timer channel event and compare control block.
// Assumes a 16-bit register port with byte addresses on a word grid.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ==========================================================
// Register byte offsets
`define TCC_OFS_FLAGS    8'h10
`define TCC_OFS_SWEVG    8'h14
`define TCC_OFS_CHCTL    8'h18
`define TCC_OFS_CV0      8'h34
`define TCC_OFS_CV1      8'h38
`define TCC_RESET_VAL    16'h0000

// ==========================================================
// Event flag and event generation bit positions
`define TCC_BIT_UPD      0
`define TCC_BIT_CC0      1
`define TCC_BIT_TRG      6
`define TCC_BIT_OC0      9

// ==========================================================
// Channel control field layout, per 8-bit channel slice
`define TCC_CH_STRIDE    8
`define TCC_F_MS_LO      0
`define TCC_F_MS_HI      1
`define TCC_F_FEN        2
`define TCC_F_SEN        3
`define TCC_F_CTL_LO     4
`define TCC_F_CTL_HI     6
`define TCC_F_CEN        7

// ==========================================================
// Direction codes
`define TCC_MS_OUT       2'h0
`define TCC_MS_ODD       2'h1
`define TCC_MS_EVEN      2'h2
`define TCC_MS_ITS       2'h3

// ==========================================================
// Compare output modes
`define TCC_OC_FROZEN    3'h0
`define TCC_OC_SET       3'h1
`define TCC_OC_CLR       3'h2
`define TCC_OC_TOGGLE    3'h3
`define TCC_OC_LOW       3'h4
`define TCC_OC_HIGH      3'h5
`define TCC_OC_PWM0      3'h6
`define TCC_OC_PWM1      3'h7

// ==========================================================
// Slave mode, protection, fast path timing
`define TCC_SM_OFF       3'h0
`define TCC_SM_PAUSE     3'h5
`define TCC_PROTECTION_LEVEL_LOCKED  2'h3
`define TCC_FAST_LAT     3
`endif

/* File: hw/tcc_channel_ctl.v */
// Event flags, software event generation and channel control for the
// low channel pair of a general-purpose timer.
// Assumes counter, slave mode, filters and protection logic sit outside
// and hand over synchronous levels and one-cycle pulses on clk.
//
// How it works
// RL1: Capture while capture flag set sets overcapture
// RL2: Trigger edges set trigger flag; pause: both
// RL3: Capture or compare event sets capture/compare flag
// RL4: Update event sets sticky update flag
// RL5: Write zero clears flag; hardware set wins
// RL6: Trigger generation bit sets trigger flag, self-clears
// RL7: Channel generation bit makes event, sets flag
// RL8: Software input event captures counter, may overcapture
// RL9: Update generation clears or reloads counter, prescaler
// RL10: Channel 0 direction selects output or input source
// RL11: Direction field writable only while channel disabled
// RL12: Channel 1 direction routes inputs swapped
// RL13: Clear enable forces reference low on trigger
// RL14: Frozen, set, clear, toggle on compare match
// RL15: Codes 100 and 101 force low or high
// RL16: PWM mode 0 levels by direction
// RL17: PWM mode 1 levels by direction
// RL18: PWM level moves only on comparison change; the code also moves it when leaving frozen
// RL19: Protection locks mode and shadow fields
// RL20: Shadow holds compare value until update
// RL21: Software uses shadow with PWM unless single pulse
// RL22: Fast enable treats trigger edge as match
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_channel_ctl #(
  parameter CHANNELS = 2,
  parameter CW       = 16
) (
  input  wire                clk,
  input  wire                rst,
  input  wire [7:0]          regAddr,
  input  wire [15:0]         regWrData,
  input  wire                regWr,
  input  wire                regRd,
  output reg  [15:0]         regRdData,
  input  wire [CW-1:0]       counterValue,
  input  wire                countDown,
  input  wire                centerAligned,
  input  wire                updateEvent,
  input  wire [2:0]          slaveMode,
  input  wire                triggerInput,
  input  wire                internalTriggerSelected,
  input  wire                internalTriggerSignal,
  input  wire [CHANNELS-1:0] chanEnableBit,
  input  wire [CHANNELS-1:0] chanFilteredInput,
  input  wire                filteredExternalTrigger,
  input  wire [1:0]          protectionLevel,
  output reg  [CHANNELS-1:0] outputReference,
  output reg  [CHANNELS-1:0] chanEventPulse,
  output reg                 trigEventPulse,
  output reg                 updateGenPulse,
  output reg                 counterClearPulse,
  output reg                 counterReloadPulse,
  output reg                 prescalerClearPulse
);

  // ==========================================================
  // Decode and shared event sources
  wire wrFlags = regWr && (regAddr == `TCC_OFS_FLAGS);
  wire wrGen   = regWr && (regAddr == `TCC_OFS_SWEVG);
  wire wrCtl   = regWr && (regAddr == `TCC_OFS_CHCTL);
  wire updGen  = wrGen && regWrData[`TCC_BIT_UPD];
  wire trgGen  = wrGen && regWrData[`TCC_BIT_TRG];
  wire loadEvt = updateEvent || updGen;
  wire locked  = (protectionLevel == `TCC_PROTECTION_LEVEL_LOCKED);

  reg                trigPrev_r;
  reg                updFlag_r;
  reg                trgFlag_r;
  reg [`TCC_FAST_LAT-2:0] fastPipe_r;

  wire [CHANNELS*`TCC_CH_STRIDE-1:0] ctlAll;
  wire [CHANNELS*CW-1:0] cvAll;
  wire [CHANNELS-1:0]    ccAll;
  wire [CHANNELS-1:0]    ocAll;
  wire [CHANNELS-1:0]    evtAll;
  wire [CHANNELS-1:0]    refAll;

  // Slave mode edges: pause counts both, other active modes only rising, off none
  wire trigRise = triggerInput && !trigPrev_r;
  wire trigFall = !triggerInput && trigPrev_r;
  wire trigHw   = (slaveMode != `TCC_SM_OFF) &&
                  (trigRise ||
                   (trigFall && slaveMode == `TCC_SM_PAUSE)); // [RL2]
  wire trigEvt  = trigHw || trgGen;                           // [RL6]

  // ==========================================================
  // Shared flags: set wins over a software clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev_r <= 1'b0;
      updFlag_r  <= 1'b0;
      trgFlag_r  <= 1'b0;
      fastPipe_r <= {(`TCC_FAST_LAT-1){1'b0}};
    end else begin
      trigPrev_r <= triggerInput;
      // Fast path delay line, edge to output in the fast latency
      fastPipe_r <= {fastPipe_r[`TCC_FAST_LAT-3:0], trigRise}; // [RL22]
      if (loadEvt)
        updFlag_r <= 1'b1;                                     // [RL4]
      else if (wrFlags && !regWrData[`TCC_BIT_UPD])
        updFlag_r <= 1'b0;                                     // [RL5]
      if (trigEvt)
        trgFlag_r <= 1'b1;                                     // [RL2]
      else if (wrFlags && !regWrData[`TCC_BIT_TRG])
        trgFlag_r <= 1'b0;                                     // [RL5]
    end
  end

  wire fastHit = fastPipe_r[`TCC_FAST_LAT-2];

  // ==========================================================
  // Per-channel control, compare value, flags and reference
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gCh
      localparam LO = g * `TCC_CH_STRIDE;
      reg [1:0]    ms_r;
      reg          fen_r;
      reg          sen_r;
      reg [2:0]    ctl_r;
      reg          cen_r;
      reg [CW-1:0] cvActive_r;
      reg [CW-1:0] cvShadow_r;
      reg          cc_r;
      reg          oc_r;
      reg          ref_r;
      reg          srcPrev_r;
      reg          cmpPrev_r;
      reg          wasFrozen_r;
      reg          pwmPrev_r;
      reg          src;

      // Own slot first for even channels, swapped for odd ones
      wire own   = chanFilteredInput[g];
      wire neigh = chanFilteredInput[g ^ 1];
      wire isIn  = (ms_r != `TCC_MS_OUT);
      wire oddSel  = (g % 2 == 0) ? own : neigh;
      wire evenSel = (g % 2 == 0) ? neigh : own;

      // Input source mux; internal trigger only when selected
      always @* begin
        case (ms_r)
          `TCC_MS_ODD:  src = oddSel;                          // [RL10]
          `TCC_MS_EVEN: src = evenSel;                         // [RL12]
          `TCC_MS_ITS:  src = internalTriggerSelected &&
                              internalTriggerSignal;           // [RL10]
          default:      src = 1'b0;
        endcase
      end

      wire swGen   = wrGen && regWrData[`TCC_BIT_CC0 + g];     // [RL7]
      wire capHw   = isIn && src && !srcPrev_r;
      wire match   = (counterValue == cvActive_r);
      wire cmpHw   = !isIn && match && !cmpPrev_r;
      wire chEvt   = capHw || cmpHw || swGen;                  // [RL3]
      wire capture = isIn && (capHw || swGen);                 // [RL8]
      wire wrCv    = regWr && !isIn &&
                     (regAddr == (g == 0 ? `TCC_OFS_CV0 : `TCC_OFS_CV1));
      wire protOk  = !(locked && ms_r == `TCC_MS_OUT);         // [RL19]
      wire isPwm   = (ctl_r == `TCC_OC_PWM0) ||
                     (ctl_r == `TCC_OC_PWM1);
      // High level of PWM mode 0; mode 1 is the inverse
      wire pwm0Lvl = countDown ? !(counterValue > cvActive_r)
                               : (counterValue < cvActive_r);  // [RL16]
      wire pwmLvl  = (ctl_r == `TCC_OC_PWM1) ? !pwm0Lvl
                                             : pwm0Lvl;        // [RL17]

      // Control fields with their write locks
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ms_r  <= `TCC_MS_OUT;
          fen_r <= 1'b0;
          sen_r <= 1'b0;
          ctl_r <= `TCC_OC_FROZEN;
          cen_r <= 1'b0;
        end else if (wrCtl) begin
          if (!chanEnableBit[g])                               // [RL11]
            ms_r <= regWrData[LO+`TCC_F_MS_HI:LO+`TCC_F_MS_LO];
          fen_r <= regWrData[LO+`TCC_F_FEN];
          cen_r <= regWrData[LO+`TCC_F_CEN];
          if (protOk) begin                                    // [RL19]
            sen_r <= regWrData[LO+`TCC_F_SEN];
            ctl_r <= regWrData[LO+`TCC_F_CTL_HI:LO+`TCC_F_CTL_LO];
          end
        end
      end

      // Compare value: shadowed or direct; capture overwrites it
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cvActive_r <= {CW{1'b0}};
          cvShadow_r <= {CW{1'b0}};
        end else begin
          if (wrCv)
            cvShadow_r <= regWrData[CW-1:0];
          if (capture)
            cvActive_r <= counterValue;                        // [RL8]
          else if (wrCv && !sen_r)
            cvActive_r <= regWrData[CW-1:0];                   // [RL20]
          else if (sen_r && loadEvt && !isIn)
            cvActive_r <= cvShadow_r;                          // [RL20]
        end
      end

      // Capture/compare and overcapture flags, set beats clear
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          cc_r      <= 1'b0;
          oc_r      <= 1'b0;
          srcPrev_r <= 1'b0;
          // Counter and compare value both reset to zero and match;
          // starting high keeps that from looking like a fresh event
          cmpPrev_r <= 1'b1;
        end else begin
          srcPrev_r <= src;
          cmpPrev_r <= match;
          if (chEvt)
            cc_r <= 1'b1;                                      // [RL3]
          else if (wrFlags && !regWrData[`TCC_BIT_CC0 + g])
            cc_r <= 1'b0;                                      // [RL5]
          if (capture && cc_r)
            oc_r <= 1'b1;                                      // [RL1]
          else if (wrFlags && !regWrData[`TCC_BIT_OC0 + g])
            oc_r <= 1'b0;                                      // [RL5]
        end
      end

      // Output reference; clear input has top priority
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ref_r       <= 1'b0;
          wasFrozen_r <= 1'b1;
        end else begin
          wasFrozen_r <= (ctl_r == `TCC_OC_FROZEN);
          if (cen_r && filteredExternalTrigger)
            ref_r <= 1'b0;                                     // [RL13]
          else if (isPwm && fen_r && fastHit)
            ref_r <= (ctl_r == `TCC_OC_PWM0);                  // [RL22]
          else begin
            case (ctl_r)
              `TCC_OC_SET:    if (cmpHw) ref_r <= 1'b1;        // [RL14]
              `TCC_OC_CLR:    if (cmpHw) ref_r <= 1'b0;        // [RL14]
              `TCC_OC_TOGGLE: if (cmpHw) ref_r <= !ref_r;      // [RL14]
              `TCC_OC_LOW:    ref_r <= 1'b0;                   // [RL15]
              `TCC_OC_HIGH:   ref_r <= 1'b1;                   // [RL15]
              `TCC_OC_PWM0,
              `TCC_OC_PWM1:
                // Only a fresh comparison or leaving frozen moves it
                if (wasFrozen_r || (pwm0Lvl != pwmPrev_r))     // [RL18]
                  ref_r <= pwmLvl;
              default:        ref_r <= ref_r;                  // [RL14]
            endcase
          end
        end
      end

      // Comparison result of the previous cycle for PWM
      always @(posedge clk or posedge rst) begin
        if (rst)
          pwmPrev_r <= 1'b0;
        else
          pwmPrev_r <= pwm0Lvl;
      end

      assign ctlAll[LO+`TCC_F_CEN:LO] = {cen_r, ctl_r, sen_r, fen_r, ms_r};
      assign cvAll[g*CW+:CW] = cvActive_r;
      assign ccAll[g]  = cc_r;
      assign ocAll[g]  = oc_r;
      assign evtAll[g] = chEvt;
      assign refAll[g] = ref_r;
    end
  endgenerate

  // ==========================================================
  // Read mux, built combinationally and registered below
  reg [15:0] rdMux;
  integer i;
  always @* begin
    rdMux = `TCC_RESET_VAL;
    case (regAddr)
      `TCC_OFS_FLAGS: begin
        rdMux[`TCC_BIT_UPD] = updFlag_r;
        rdMux[`TCC_BIT_TRG] = trgFlag_r;
        for (i = 0; i < CHANNELS; i = i + 1) begin
          rdMux[`TCC_BIT_CC0 + i] = ccAll[i];
          rdMux[`TCC_BIT_OC0 + i] = ocAll[i];
        end
      end
      `TCC_OFS_CHCTL: rdMux[CHANNELS*`TCC_CH_STRIDE-1:0] = ctlAll;
      `TCC_OFS_CV0:   rdMux[CW-1:0] = cvAll[CW-1:0];
      `TCC_OFS_CV1:   rdMux[CW-1:0] = cvAll[2*CW-1:CW];
      default:        rdMux = `TCC_RESET_VAL;
    endcase
  end

  // ==========================================================
  // Registered outputs; generation bits never store, so they
  // read back zero and clear themselves after one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData           <= `TCC_RESET_VAL;
      outputReference     <= {CHANNELS{1'b0}};
      chanEventPulse      <= {CHANNELS{1'b0}};
      trigEventPulse      <= 1'b0;
      updateGenPulse      <= 1'b0;
      counterClearPulse   <= 1'b0;
      counterReloadPulse  <= 1'b0;
      prescalerClearPulse <= 1'b0;
    end else begin
      regRdData           <= regRd ? rdMux : `TCC_RESET_VAL;
      outputReference     <= refAll;
      chanEventPulse      <= evtAll;                           // [RL7]
      trigEventPulse      <= trigEvt;                          // [RL6]
      updateGenPulse      <= updGen;                           // [RL9]
      counterClearPulse   <= updGen && (centerAligned || !countDown); // [RL9]
      counterReloadPulse  <= updGen && !centerAligned && countDown;   // [RL9]
      prescalerClearPulse <= updGen;                           // [RL9]
    end
  end

endmodule // tcc_channel_ctl

/* File: tb/tcc_channel_ctl_props.sv */
// Port checker for the timer channel event and compare control block.
// Assumes the register port contract: read data one cycle after strobe.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_channel_ctl_props #(
  parameter CHANNELS = 2
) (
  input wire                clk,
  input wire                rst,
  input wire [7:0]          regAddr,
  input wire [15:0]         regWrData,
  input wire                regWr,
  input wire                regRd,
  input wire [15:0]         regRdData,
  input wire                countDown,
  input wire                centerAligned,
  input wire                updateEvent,
  input wire [2:0]          slaveMode,
  input wire                triggerInput,
  input wire [CHANNELS-1:0] chanEventPulse,
  input wire                trigEventPulse,
  input wire                updateGenPulse,
  input wire                counterClearPulse,
  input wire                counterReloadPulse,
  input wire                prescalerClearPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Decoded strobes
  wire genWr  = regWr && regAddr == `TCC_OFS_SWEVG;
  wire flagRd = regRd && regAddr == `TCC_OFS_FLAGS;
  wire updUp  = centerAligned || !countDown;

  // ==========================================================
  // Software event generation
  chk_trig_gen_pulse: assert property (
    genWr && regWrData[`TCC_BIT_TRG] |=> trigEventPulse)
    else $error("trigger generation gave no trigger pulse");
  chk_chan_gen_pulse: assert property (
    genWr && regWrData[`TCC_BIT_CC0] |=> chanEventPulse[0])
    else $error("channel generation gave no channel event");
  chk_upd_gen_clear: assert property (
    genWr && regWrData[0] && updUp
    |=> updateGenPulse && counterClearPulse && prescalerClearPulse &&
        !counterReloadPulse)
    else $error("update generation did not clear the counter");
  chk_upd_gen_load: assert property (
    genWr && regWrData[0] && !updUp
    |=> updateGenPulse && counterReloadPulse && prescalerClearPulse &&
        !counterClearPulse)
    else $error("update generation did not reload the counter");
  chk_gen_reads_zero: assert property (
    regRd && regAddr == `TCC_OFS_SWEVG |=> regRdData == 16'h0000)
    else $error("event generation bits did not clear");

  // ==========================================================
  // Flags seen through a read right after their cause
  chk_upd_flag_read: assert property (
    updateEvent ##1 !regWr ##1 flagRd |=> regRdData[`TCC_BIT_UPD])
    else $error("update flag missing after update event");
  chk_cc_flag_read: assert property (
    chanEventPulse[0] && !regWr ##1 flagRd |=> regRdData[`TCC_BIT_CC0])
    else $error("capture compare flag missing after event");

  // ==========================================================
  // Trigger edges; the detector may add one stage
  chk_trig_active_edge: assert property (
    slaveMode != `TCC_SM_OFF && $rose(triggerInput)
    |-> ##[1:2] trigEventPulse)
    else $error("active trigger edge gave no trigger event");
  chk_trig_pause_fall: assert property (
    slaveMode == `TCC_SM_PAUSE && $fell(triggerInput)
    |-> ##[1:2] trigEventPulse)
    else $error("pause mode falling edge gave no trigger event");

  cov_trig_gen: cover property (genWr && regWrData[`TCC_BIT_TRG]);
  cov_upd_read: cover property (updateEvent ##1 !regWr ##1 flagRd);
  cov_cc_read: cover property (chanEventPulse[0] && !regWr ##1 flagRd);
endmodule // tcc_channel_ctl_props

bind tcc_channel_ctl tcc_channel_ctl_props #(.CHANNELS(CHANNELS))
  i_tcc_channel_ctl_props (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .countDown(countDown), .centerAligned(centerAligned),
  .updateEvent(updateEvent), .slaveMode(slaveMode),
  .triggerInput(triggerInput), .chanEventPulse(chanEventPulse),
  .trigEventPulse(trigEventPulse), .updateGenPulse(updateGenPulse),
  .counterClearPulse(counterClearPulse),
  .counterReloadPulse(counterReloadPulse),
  .prescalerClearPulse(prescalerClearPulse));

/* File: tb/tcc_channel_ctl_bench.sv */
// Self-checking bench for the timer channel event and compare control.
// Assumes the block stands alone; the bench drives every input itself.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_channel_ctl_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  regAddr = 8'h00;
  reg  [15:0] regWrData = 16'h0000;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  wire [15:0] regRdData;
  reg  [15:0] counterValue = 16'h0000;
  reg         countDown = 1'b0;
  reg         updateEvent = 1'b0;
  reg  [2:0]  slaveMode = 3'h0;
  reg         triggerInput = 1'b0;
  reg  [1:0]  chanEnableBit = 2'h0;
  reg  [1:0]  chanInput = 2'h0;
  reg         extTrig = 1'b0;
  reg  [1:0]  protectionLevel = 2'h0;
  reg         centerAligned = 1'b0;
  reg         itsSel = 1'b0;
  reg         itsSig = 1'b0;
  wire [1:0]  outputReference;
  integer     n_errors = 0;
  integer     total_checks = 0;
  integer     i;

  tcc_channel_ctl i_tcc_channel_ctl (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .counterValue(counterValue), .countDown(countDown),
    .centerAligned(centerAligned), .updateEvent(updateEvent),
    .slaveMode(slaveMode), .triggerInput(triggerInput),
    .internalTriggerSelected(itsSel), .internalTriggerSignal(itsSig),
    .chanEnableBit(chanEnableBit), .chanFilteredInput(chanInput),
    .filteredExternalTrigger(extTrig), .protectionLevel(protectionLevel),
    .outputReference(outputReference), .chanEventPulse(),
    .trigEventPulse(), .updateGenPulse(), .counterClearPulse(),
    .counterReloadPulse(), .prescalerClearPulse());

  // ==========================================================
  // Clock and shared bus tasks
  initial begin
    forever #12.5 clk = ~clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rdchk(input [7:0] a, input [15:0] e, input string what);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(what, regRdData, e);
    @(posedge clk);
  endtask
  // Reference is registered twice, so give it a few cycles
  task refchk(input e);
    cyc(4);
    @(negedge clk);
    chk("ref0", {15'h0, outputReference[0]}, {15'h0, e});
    @(posedge clk);
  endtask
  task pin(input [1:0] v);
    @(posedge clk);
    chanInput <= v;
    cyc(2);
    chanInput <= 2'h0;
    cyc(3);
  endtask
  task updPulse;
    @(posedge clk);
    updateEvent <= 1'b1;
    @(posedge clk);
    updateEvent <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task t_events;
    rdchk(`TCC_OFS_CHCTL, `TCC_RESET_VAL, "ctl");
    rdchk(`TCC_OFS_FLAGS, `TCC_RESET_VAL, "flags");
    rdchk(8'h3c, 16'h0000, "unmapped");
    wr(`TCC_OFS_SWEVG, 16'h0047);
    rdchk(`TCC_OFS_FLAGS, 16'h0047, "flags");
    rdchk(`TCC_OFS_SWEVG, 16'h0000, "evgen");
    wr(`TCC_OFS_FLAGS, 16'h0046);
    rdchk(`TCC_OFS_FLAGS, 16'h0046, "flags");
    countDown <= 1'b1;
    wr(`TCC_OFS_SWEVG, 16'h0001);
    // Center-aligned clears even when counting down
    centerAligned <= 1'b1;
    wr(`TCC_OFS_SWEVG, 16'h0001);
    countDown <= 1'b0;
    centerAligned <= 1'b0;
    wr(`TCC_OFS_FLAGS, 16'h0000);
    updPulse;
    rdchk(`TCC_OFS_FLAGS, 16'h0001, "upd flag");
    // Hardware set and software clear in one cycle
    @(posedge clk);
    updateEvent <= 1'b1;
    regWr <= 1'b1;
    regAddr <= `TCC_OFS_FLAGS;
    regWrData <= 16'h0000;
    @(posedge clk);
    updateEvent <= 1'b0;
    regWr <= 1'b0;
    rdchk(`TCC_OFS_FLAGS, 16'h0001, "set wins");
    wr(`TCC_OFS_FLAGS, 16'h0000);
    rdchk(`TCC_OFS_FLAGS, 16'h0000, "cleared");
    $display("test events done");
  endtask

  task t_capture;
    counterValue <= 16'h1234;
    wr(`TCC_OFS_CHCTL, 16'h0101);
    pin(2'h1);
    rdchk(`TCC_OFS_FLAGS, 16'h0006, "capture");
    pin(2'h1);
    rdchk(`TCC_OFS_FLAGS, 16'h0606, "overcap");
    wr(`TCC_OFS_FLAGS, 16'h0000);
    pin(2'h2);
    rdchk(`TCC_OFS_FLAGS, 16'h0000, "routing");
    counterValue <= 16'h0abc;
    wr(`TCC_OFS_SWEVG, 16'h0002);
    rdchk(`TCC_OFS_CV0, 16'h0abc, "cap value");
    wr(`TCC_OFS_SWEVG, 16'h0002);
    rdchk(`TCC_OFS_FLAGS, 16'h0202, "sw overcap");
    chanEnableBit <= 2'h3;
    wr(`TCC_OFS_CHCTL, 16'h0000);
    rdchk(`TCC_OFS_CHCTL, 16'h0101, "dir lock");
    chanEnableBit <= 2'h0;
    wr(`TCC_OFS_CHCTL, 16'h0000);
    rdchk(`TCC_OFS_CHCTL, 16'h0000, "dir free");
    // Internal trigger source only captures while it is selected
    wr(`TCC_OFS_CHCTL, 16'h0003);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`TCC_OFS_FLAGS, 16'h0000);
      itsSel <= i[0];
      itsSig <= 1'b1;
      cyc(3);
      rdchk(`TCC_OFS_FLAGS, {14'h0, i[0], 1'b0}, "its cap");
      itsSig <= 1'b0;
    end
    $display("test capture done");
  endtask

  task t_output;
    localparam [14:0] MM = {3'h3, 3'h3, 3'h1, 3'h0, 3'h2};
    localparam [4:0]  ME = 5'b10100;
    // PWM table: mode 7 bits, down bits, high count bits, expected
    localparam [5:0]  P7 = 6'b001100;
    localparam [5:0]  PD = 6'b110000;
    localparam [5:0]  PC = 6'b011010;
    localparam [5:0]  PE = 6'b101001;
    counterValue <= 16'h0000;
    wr(`TCC_OFS_CHCTL, 16'h0040);
    refchk(1'b0);
    wr(`TCC_OFS_CHCTL, 16'h0050);
    refchk(1'b1);
    wr(`TCC_OFS_CHCTL, 16'h00d0);
    extTrig <= 1'b1;
    refchk(1'b0);
    extTrig <= 1'b0;
    refchk(1'b1);
    wr(`TCC_OFS_CV0, 16'h0010);
    for (i = 0; i < 5; i = i + 1) begin
      wr(`TCC_OFS_CHCTL, {9'h0, MM[3*i +: 3], 4'h0});
      counterValue <= 16'h0010;
      refchk(ME[i]);
      counterValue <= 16'h0000;
      cyc(2);
    end
    for (i = 0; i < 6; i = i + 1) begin
      // Pass through frozen so each PWM entry takes its level afresh
      wr(`TCC_OFS_CHCTL, 16'h0000);
      wr(`TCC_OFS_CHCTL, {9'h0, 2'h3, P7[i], 4'h0});
      countDown <= PD[i];
      counterValue <= PC[i] ? 16'h0020 : 16'h0005;
      refchk(PE[i]);
    end
    countDown <= 1'b0;
    counterValue <= 16'h0020;
    wr(`TCC_OFS_CHCTL, 16'h0068);
    wr(`TCC_OFS_CV0, 16'h0030);
    refchk(1'b0);
    updPulse;
    refchk(1'b1);
    protectionLevel <= 2'h3;
    wr(`TCC_OFS_CHCTL, 16'h0050);
    rdchk(`TCC_OFS_CHCTL, 16'h0068, "protection_level lock");
    protectionLevel <= 2'h0;
    wr(`TCC_OFS_CHCTL, 16'h0050);
    rdchk(`TCC_OFS_CHCTL, 16'h0050, "protection_level free");
    // Fast enable: a trigger edge acts as a match in PWM mode 0
    wr(`TCC_OFS_CHCTL, 16'h0064);
    counterValue <= 16'h0040;
    refchk(1'b0);
    triggerInput <= 1'b1;
    refchk(1'b1);
    triggerInput <= 1'b0;
    $display("test output done");
  endtask

  task trg(input lvl, input [15:0] e);
    wr(`TCC_OFS_FLAGS, 16'h0000);
    triggerInput <= lvl;
    cyc(3);
    rdchk(`TCC_OFS_FLAGS, e, "trig flag");
  endtask
  task t_trigger;
    slaveMode <= `TCC_SM_PAUSE;
    trg(1'b1, 16'h0040);
    trg(1'b0, 16'h0040);
    slaveMode <= 3'h4;
    trg(1'b1, 16'h0040);
    trg(1'b0, 16'h0000);
    $display("test trigger done");
  endtask

  // ==========================================================
  // Verdict, watchdog and main sequence
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 25);
    n_errors = n_errors + 1;
    finish_test;
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    t_events;
    t_capture;
    t_output;
    t_trigger;
    finish_test;
  end
endmodule // tcc_channel_ctl_bench
